// ### core/rfac_consts.svh
`ifndef RFAC_CONSTS_SVH
`define RFAC_CONSTS_SVH
// Register byte addresses on the AHB-Lite slave.
`define RFAC_OFS_CTRL 8'h00
`define RFAC_OFS_STATUS 8'h04
`define RFAC_OFS_ADDR 8'h08
`define RFAC_OFS_LEVEL 8'h0C
`define RFAC_OFS_CALRES 8'h10
// Control register fields.
`define RFAC_CTRL_OPT_BIT 0
`define RFAC_CTRL_REM_BIT 1
`define RFAC_CTRL_INTYPE_LSB 4
`define RFAC_CTRL_OMODE_LSB 8
`define RFAC_CTRL_RESET 32'h0000_0001
// Framing characters.
`define RFAC_ACK 8'h06
`define RFAC_BEL 8'h07
`define RFAC_SEMI 8'h3B
`define RFAC_QMARK 8'h3F
`define RFAC_CHX 8'h58
`define RFAC_CH0 8'h30
// Acceptance windows: cutoffs in Hz, alarm levels in tenths of a percent.
`define RFAC_LO_MIN 32'd5
`define RFAC_LO_MAX 32'd500
`define RFAC_HI_MIN 32'd50
`define RFAC_HI_MAX 32'd5000
`define RFAC_ALM_MIN 32'd10
`define RFAC_ALM_MAX 32'd1000
// Calibration may take up to three minutes.
`define RFAC_CAL_TIME_S 180
`define RFAC_CLK_HZ 10000000
`define RFAC_CAL_CYCLES (`RFAC_CAL_TIME_S * `RFAC_CLK_HZ)
`endif

// ### core/rfac_core.sv
// What this block does
// RULE1: F0 filter out, F1 filter in.
// RULE2: Accepted setting sends no reply.
// RULE3: Filter failure: E0 absent, E1 refused, BEL.
// RULE4: F? replies state digit with ACK.
// RULE5: Filter state kept per input/mode, saved.
// RULE6: Power-up loads saved corner frequencies.
// RULE7: L/U carry five-byte floating cutoff.
// RULE8: Lower 5-500 Hz, upper 50-5000 Hz.
// RULE9: L?/U? reply letter, value, ACK.
// RULE10: After cutoff apply, back to normal.
// RULE11: Cutoffs kept per input/mode, saved.
// RULE12: W warning, A alert, percent value.
// RULE13: Levels 1.0-100.0 percent; 100 disables.
// RULE14: Alarm level failure gives E1 BEL.
// RULE15: Alarm levels saved and reloaded.
// RULE16: Crossing sends K0/K1 with BEL unprompted.
// RULE17: Alarms latch; K? reports with BEL.
// RULE18: R clears both alarm latches.
// RULE19: W?/A? reply letter, value, ACK.
// RULE20: C calibrates, echo C with BEL.
// RULE21: Bad reference gives E7, keep calibration.
// RULE22: Host selects unit before queries.
// RULE23: Query replaces byte 1 with question mark.
// RULE24: Remote only after Z, drops on disconnect.
// RULE25: ACK is 06, BEL is 07.
// RULE26: Unknown letter ignored, nothing changes.
`include "rfac_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module rfac_core #(
	parameter int CAL_CYCLES = `RFAC_CAL_CYCLES,
	parameter int SLOTS = 16
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic link_present_pin,
	input wire logic warn_over_pin,
	input wire logic alert_over_pin,
	input wire logic cal_done,
	input wire logic cal_ok,
	output logic cal_start,
	input wire rfac_pkg::rfac_set_type nv_load_data,
	input wire logic nv_load_valid,
	output rfac_pkg::rfac_nv_type nv_store,
	output logic filt_in_out,
	output logic [31:0] lo_hz_out,
	output logic [31:0] hi_hz_out,
	input wire logic hclk_sel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	// Pins from outside pass two flip-flops before use.
	logic [2:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {alert_over_pin, warn_over_pin, link_present_pin};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire link_ok = pin_s2_q[0];
	wire warn_over = pin_s2_q[1];
	wire alert_over = pin_s2_q[2];

	// Control register: option present, remote mode flag, selector and unit address.
	logic [31:0] ctrl_q;
	logic [7:0] unit_addr_q;
	logic [7:0] sel_addr_q;
	logic remote_q;
	wire opt_present = ctrl_q[`RFAC_CTRL_OPT_BIT];
	wire [3:0] slot_sel = {ctrl_q[`RFAC_CTRL_INTYPE_LSB +: 2], ctrl_q[`RFAC_CTRL_OMODE_LSB +: 2]};
	// Addressed mode requires remote operation and this unit being selected.
	wire addressed = remote_q && (sel_addr_q == unit_addr_q);

	// Settings table, one entry per input type and output mode.
	rfac_pkg::rfac_set_type tbl_q [SLOTS];
	rfac_pkg::rfac_set_type cur;
	assign cur = tbl_q[slot_sel];

	// Command frame: six bytes then semicolon.
	logic [7:0] frame_q [7];
	logic [2:0] rx_cnt_q;
	rfac_pkg::rfac_state_type state_q;
	wire frame_end = rx_valid && state_q == rfac_pkg::RFAC_IDLE && rx_cnt_q == 3'd6;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_cnt_q <= 3'd0;
		end else if (rx_valid && state_q == rfac_pkg::RFAC_IDLE) begin
			rx_cnt_q <= (rx_cnt_q == 3'd6) ? 3'd0 : rx_cnt_q + 3'd1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rx_valid && state_q == rfac_pkg::RFAC_IDLE) begin
			frame_q[rx_cnt_q] <= rx_data;
		end
	end

	// Decode the five value bytes as 0.d0d1d2d3 * 10^e in a scaled integer.
	wire [7:0] cmd = frame_q[0];
	wire is_query = frame_q[1] == `RFAC_QMARK; // RULE23
	function automatic logic [31:0] digits4(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d);
		digits4 = 32'(a[3:0]) * 32'd1000 + 32'(b[3:0]) * 32'd100 + 32'(c[3:0]) * 32'd10
			+ 32'(d[3:0]);
	endfunction
	wire [31:0] mant = digits4(frame_q[1], frame_q[2], frame_q[3], frame_q[4]);
	wire [3:0] expo = frame_q[5][3:0];
	// Value in units (Hz) = mant * 10^(e-4); levels in tenths = mant * 10^(e-3).
	function automatic logic [31:0] scale(input logic [31:0] m, input logic [3:0] e,
		input logic [3:0] drop);
		logic [31:0] v;
		v = m;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < e) v = v * 32'd10;
		end
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < drop) v = v / 32'd10;
		end
		scale = v;
	endfunction
	wire [31:0] val_hz = scale(mant, expo, 4'd4); // RULE7
	wire [31:0] val_pm = scale(mant, expo, 4'd3); // RULE12
	wire lo_ok = val_hz >= `RFAC_LO_MIN && val_hz <= `RFAC_LO_MAX; // RULE8
	wire hi_ok = val_hz >= `RFAC_HI_MIN && val_hz <= `RFAC_HI_MAX; // RULE8
	wire alm_ok = val_pm >= `RFAC_ALM_MIN && val_pm <= `RFAC_ALM_MAX; // RULE13
	wire dig_ok = frame_q[1] == `RFAC_CH0 || frame_q[1] == `RFAC_CH0 + 8'h01;

	// Reply buffer: six bytes and a terminator.
	logic [7:0] reply_q [7];
	logic [2:0] tx_cnt_q;
	// A byte only counts as sent when the host saw it valid and ready at the same edge.
	wire tx_fire = tx_valid && tx_ready;
	wire [2:0] tx_cnt_d = !tx_fire ? tx_cnt_q : (tx_cnt_q == 3'd6) ? 3'd0 : tx_cnt_q + 3'd1;
	logic warn_lat_q, alert_lat_q, warn_prev_q, alert_prev_q;
	logic [1:0] evt_pend_q;
	logic [31:0] cal_cnt_q;
	logic [1:0] cal_result_q;
	logic boot_q;

	// Build a reply from a letter, five payload bytes and terminator.
	task automatic make_reply(input logic [7:0] l, input logic [39:0] p, input logic [7:0] t);
		reply_q[0] <= l;
		for (int i = 0; i < 5; i++) begin
			reply_q[i + 1] <= p[39 - 8 * i -: 8];
		end
		reply_q[6] <= t;
	endtask
	function automatic logic [39:0] enc(input logic [31:0] v);
		enc = {8'h30 + 8'(v / 32'd1000 % 32'd10), 8'h30 + 8'(v / 32'd100 % 32'd10),
			8'h30 + 8'(v / 32'd10 % 32'd10), 8'h30 + 8'(v % 32'd10), 8'h34};
	endfunction
	wire [39:0] pad = {5{`RFAC_CHX}};
	// Levels are held in tenths of a percent, so their replies carry exponent 3 to keep the tenth.
	wire [39:0] warn_enc = enc(cur.warn_pm);
	wire [39:0] alert_enc = enc(cur.alert_pm);

	// Main sequencer: executes a frame, sends replies, runs calibration.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= rfac_pkg::RFAC_IDLE;
			tx_cnt_q <= 3'd0;
			remote_q <= 1'b0;
			sel_addr_q <= 8'h00;
			warn_lat_q <= 1'b0;
			alert_lat_q <= 1'b0;
			warn_prev_q <= 1'b0;
			alert_prev_q <= 1'b0;
			evt_pend_q <= 2'b00;
			cal_start <= 1'b0;
			cal_cnt_q <= 32'd0;
			cal_result_q <= 2'b00;
			nv_store <= '0;
			boot_q <= 1'b1;
			for (int i = 0; i < 7; i++) reply_q[i] <= 8'h00;
			for (int i = 0; i < SLOTS; i++) tbl_q[i] <= '0;
		end else begin
			cal_start <= 1'b0;
			nv_store.wr <= 1'b0;
			nv_store.data <= cur;
			warn_prev_q <= warn_over;
			alert_prev_q <= alert_over;
			// Latch alarms on rising crossings; set beats the reset command.
			if (warn_over && !warn_prev_q && cur.warn_pm != `RFAC_ALM_MAX) begin // RULE13
				warn_lat_q <= 1'b1; // RULE17
				if (addressed) evt_pend_q[0] <= 1'b1; // RULE16
			end else if (state_q == rfac_pkg::RFAC_EXEC && cmd == "R") begin
				warn_lat_q <= 1'b0; // RULE18
			end
			if (alert_over && !alert_prev_q && cur.alert_pm != `RFAC_ALM_MAX) begin
				alert_lat_q <= 1'b1; // RULE17
				if (addressed) evt_pend_q[1] <= 1'b1; // RULE16
			end else if (state_q == rfac_pkg::RFAC_EXEC && cmd == "R") begin
				alert_lat_q <= 1'b0; // RULE18
			end
			if (!link_ok) remote_q <= 1'b0; // RULE24
			// Saved defaults arrive once from memory after power-up.
			if (boot_q && nv_load_valid) begin
				for (int i = 0; i < SLOTS; i++) tbl_q[i] <= nv_load_data; // RULE6 RULE15
				boot_q <= 1'b0;
			end
			case (state_q)
			rfac_pkg::RFAC_IDLE: begin
				if (frame_end) begin
					state_q <= rfac_pkg::RFAC_EXEC;
				end else if (evt_pend_q[1]) begin
					make_reply("K", {`RFAC_CH0 + 8'h01, {4{`RFAC_CHX}}}, `RFAC_BEL); // RULE16
					evt_pend_q[1] <= 1'b0;
					state_q <= rfac_pkg::RFAC_SEND;
				end else if (evt_pend_q[0]) begin
					make_reply("K", {`RFAC_CH0, {4{`RFAC_CHX}}}, `RFAC_BEL); // RULE16
					evt_pend_q[0] <= 1'b0;
					state_q <= rfac_pkg::RFAC_SEND;
				end
			end
			rfac_pkg::RFAC_EXEC: begin
				// Default: setting accepted silently, back to normal.
				state_q <= rfac_pkg::RFAC_IDLE; // RULE2 RULE10
				if (cmd == "Z") begin
					remote_q <= link_ok; // RULE24
				end else if (cmd == "I") begin
					sel_addr_q <= {frame_q[1][3:0], frame_q[2][3:0]}; // RULE22
				end else if (!remote_q) begin
					state_q <= rfac_pkg::RFAC_IDLE;
				end else if (is_query) begin
					state_q <= addressed ? rfac_pkg::RFAC_SEND : rfac_pkg::RFAC_IDLE;
					case (cmd)
					"F": make_reply("F", {`RFAC_CH0 + 8'(cur.filt_in), 32'h5858_5858},
						`RFAC_ACK); // RULE4 RULE25
					"L": make_reply("L", enc(cur.lo_hz), `RFAC_ACK); // RULE9
					"U": make_reply("U", enc(cur.hi_hz), `RFAC_ACK); // RULE9
					"W": make_reply("W", {warn_enc[39:8], `RFAC_CH0 + 8'h03},
						`RFAC_ACK); // RULE19
					"A": make_reply("A", {alert_enc[39:8], `RFAC_CH0 + 8'h03},
						`RFAC_ACK); // RULE19
					"K": make_reply("K", {`RFAC_CH0 + 8'(alert_lat_q), 32'h5858_5858},
						`RFAC_BEL); // RULE17
					default: state_q <= rfac_pkg::RFAC_IDLE; // RULE26
					endcase
				end else begin
					case (cmd)
					"F", "L", "U": begin
						if (!opt_present || !(cmd == "F" ? dig_ok : cmd == "L" ? lo_ok : hi_ok)) begin
							make_reply("E", {!opt_present ? `RFAC_CH0 : `RFAC_CH0 + 8'h01, 32'h5858_5858},
								`RFAC_BEL); // RULE3 RULE10
							if (addressed) state_q <= rfac_pkg::RFAC_SEND;
						end else begin
							if (cmd == "F") tbl_q[slot_sel].filt_in <= frame_q[1][0]; // RULE1 RULE5
							if (cmd == "L") tbl_q[slot_sel].lo_hz <= val_hz; // RULE11
							if (cmd == "U") tbl_q[slot_sel].hi_hz <= val_hz; // RULE11
							nv_store.wr <= 1'b1;
							nv_store.slot <= slot_sel;
						end
					end
					"W", "A": begin
						if (!alm_ok) begin
							make_reply("E", {`RFAC_CH0 + 8'h01, 32'h5858_5858}, `RFAC_BEL); // RULE14
							if (addressed) state_q <= rfac_pkg::RFAC_SEND;
						end else begin
							if (cmd == "W") tbl_q[slot_sel].warn_pm <= val_pm;
							else tbl_q[slot_sel].alert_pm <= val_pm;
							nv_store.wr <= 1'b1; // RULE15
							nv_store.slot <= slot_sel;
						end
					end
					"C": begin
						cal_start <= 1'b1; // RULE20
						cal_cnt_q <= 32'(CAL_CYCLES);
						state_q <= rfac_pkg::RFAC_CAL;
					end
					default: ; // RULE26
					endcase
				end
			end
			rfac_pkg::RFAC_CAL: begin
				if (cal_cnt_q != 32'd0) cal_cnt_q <= cal_cnt_q - 32'd1;
				if (cal_done || cal_cnt_q == 32'd0) begin
					cal_result_q <= {1'b1, cal_done && cal_ok};
					if (cal_done && cal_ok) make_reply("C", pad, `RFAC_BEL); // RULE20
					else make_reply("E", {`RFAC_CH0 + 8'h07, 32'h5858_5858}, `RFAC_BEL); // RULE21
					state_q <= addressed ? rfac_pkg::RFAC_SEND : rfac_pkg::RFAC_IDLE;
				end
			end
			rfac_pkg::RFAC_SEND: begin
				if (tx_fire) begin
					tx_cnt_q <= tx_cnt_d;
					if (tx_cnt_q == 3'd6) state_q <= rfac_pkg::RFAC_IDLE;
				end
			end
			default: state_q <= rfac_pkg::RFAC_IDLE;
			endcase
		end
	end

	// Serial byte output and applied settings, all registered.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			filt_in_out <= 1'b0;
			lo_hz_out <= 32'd0;
			hi_hz_out <= 32'd0;
		end else begin
			tx_valid <= state_q == rfac_pkg::RFAC_SEND && !(tx_fire && tx_cnt_q == 3'd6);
			tx_data <= reply_q[tx_cnt_d];
			filt_in_out <= cur.filt_in & opt_present; // RULE1
			lo_hz_out <= cur.lo_hz;
			hi_hz_out <= cur.hi_hz;
		end
	end

	// AHB-Lite slave: one-cycle address phase, zero-wait data phase.
	logic ph_wr_q, ph_act_q;
	logic [7:0] ph_addr_q;
	wire ahb_sel = htrans[1] && hclk_sel;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_wr_q <= 1'b0;
			ph_act_q <= 1'b0;
			ph_addr_q <= 8'h00;
			ctrl_q <= `RFAC_CTRL_RESET;
			unit_addr_q <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ph_act_q <= ahb_sel;
			ph_wr_q <= ahb_sel && hwrite;
			ph_addr_q <= haddr;
			if (ph_wr_q && ph_addr_q == `RFAC_OFS_CTRL) ctrl_q <= hwdata;
			if (ph_wr_q && ph_addr_q == `RFAC_OFS_ADDR) unit_addr_q <= hwdata[7:0];
			case (haddr)
			`RFAC_OFS_CTRL: hrdata <= ctrl_q;
			`RFAC_OFS_STATUS: hrdata <= {24'h0, 1'(addressed), 1'(remote_q), cal_result_q,
				alert_lat_q, warn_lat_q, 2'(evt_pend_q != 2'b00)};
			`RFAC_OFS_ADDR: hrdata <= {sel_addr_q, 16'h0, unit_addr_q};
			`RFAC_OFS_LEVEL: hrdata <= cur.warn_pm;
			`RFAC_OFS_CALRES: hrdata <= cur.alert_pm;
			default: hrdata <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### core/rfac_pkg.sv
package rfac_pkg;
	// One stored setting set for a given input type and output mode.
	typedef struct packed {
		logic filt_in;
		logic [31:0] lo_hz;
		logic [31:0] hi_hz;
		logic [31:0] warn_pm;
		logic [31:0] alert_pm;
	} rfac_set_type;
	// Non-volatile store request towards the instrument memory.
	typedef struct packed {
		logic wr;
		logic [3:0] slot;
		rfac_set_type data;
	} rfac_nv_type;
	typedef enum logic [2:0] {
		RFAC_IDLE,
		RFAC_EXEC,
		RFAC_SEND,
		RFAC_CAL
	} rfac_state_type;
endpackage

// ### test/rfac_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module rfac_core_chk #(
	parameter int CAL_CYCLES = 100,
	parameter int SLOTS = 16
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic cal_start,
	input wire logic [31:0] lo_hz_out,
	input wire logic [31:0] hi_hz_out,
	input wire logic hreadyout,
	input wire logic hresp
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	// Byte position inside the reply in flight; a reply is always seven bytes long.
	assign cnt_d = (cnt_q == 3'h6) ? 3'h0 : cnt_q + 3'h1;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 3'h0;
		end else if (tx_valid && tx_ready) begin
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_term_code: assert property (tx_valid && cnt_q == 3'h6 |->
		tx_data == 8'h06 || tx_data == 8'h07) else $error("reply terminator wrong");
	a_first_letter: assert property (tx_valid && cnt_q == 3'h0 |->
		tx_data >= 8'h41 && tx_data <= 8'h5A) else $error("reply letter wrong");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("reply byte not held");
	a_reply_len: assert property ($fell(tx_valid) |->
		$past(tx_ready) && $past(cnt_q) == 3'h6) else $error("reply cut short");
	a_cal_pulse: assert property ($rose(cal_start) |=> !cal_start)
		else $error("calibration start too long");
	a_lo_window: assert property ($changed(lo_hz_out) |->
		lo_hz_out >= 32'd5 && lo_hz_out <= 32'd500) else $error("lower cutoff outside window");
	a_hi_window: assert property ($changed(hi_hz_out) |->
		hi_hz_out >= 32'd50 && hi_hz_out <= 32'd5000) else $error("upper cutoff outside window");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	// Main scenarios: acknowledged reply, bell reply, calibration launch.
	c_ack: cover property (tx_valid && tx_ready && cnt_q == 3'h6 && tx_data == 8'h06);
	c_bel: cover property (tx_valid && tx_ready && cnt_q == 3'h6 && tx_data == 8'h07);
	c_cal: cover property ($rose(cal_start));
endmodule
bind rfac_core rfac_core_chk #(.CAL_CYCLES(CAL_CYCLES), .SLOTS(SLOTS)) i_rfac_core_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .tx_data(tx_data), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .cal_start(cal_start), .lo_hz_out(lo_hz_out),
	.hi_hz_out(hi_hz_out), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ### test/rfac_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rfac_core_tb;
	logic sys_clk, arst_n, tx_valid, tx_ready, rx_valid, link_present_pin, warn_over_pin;
	logic alert_over_pin, cal_done, cal_ok, cal_start, nv_load_valid, filt_in_out, hclk_sel;
	logic hwrite, hreadyout, hresp, nv_seen;
	logic [7:0] tx_data, rx_data, haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] lo_hz_out, hi_hz_out, hwdata, hrdata, rd;
	rfac_pkg::rfac_set_type nv_load_data;
	rfac_pkg::rfac_nv_type nv_store;
	int n_fail = 0;
	int n_tests = 0;
	int v;
	string bad[4] = '{"L00044", "L05014", "U00494", "U50014"};
	rfac_core #(.CAL_CYCLES(100)) i_rfac_core (.sys_clk(sys_clk), .arst_n(arst_n),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .link_present_pin(link_present_pin),
		.warn_over_pin(warn_over_pin), .alert_over_pin(alert_over_pin), .cal_done(cal_done),
		.cal_ok(cal_ok), .cal_start(cal_start), .nv_load_data(nv_load_data),
		.nv_load_valid(nv_load_valid), .nv_store(nv_store), .filt_in_out(filt_in_out),
		.lo_hz_out(lo_hz_out), .hi_hz_out(hi_hz_out), .hclk_sel(hclk_sel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	rfac_host i_host (.sys_clk(sys_clk), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
	// Free-running bench clock at 10 MHz.
	always #50 sys_clk = ~sys_clk;
	// Any store request to the memory is remembered for a later check.
	always @(posedge sys_clk) if (nv_store.wr === 1'b1) nv_seen = 1'b1;
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1) break;
		end
		if (n == 50) begin
			n_fail++;
			end_sim();
		end
	endtask
	// One single-word transfer: address phase, then data phase, each held until ready.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		hclk_sel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	// Expected reply is built from the given reply text and terminator, so nothing is read back from the design.
	task automatic reply(input string s, input logic [7:0] t);
		logic [63:0] x;
		x = 64'h0;
		for (int n = 0; n < 600 && i_host.got_q.size() < 7; n++) @(posedge sys_clk);
		if (i_host.got_q.size() < 7) begin
			n_fail++;
			end_sim();
		end
		for (int i = 0; i < 7; i++) x = {x[55:0], i_host.got_q.pop_front()};
		chk(x, {8'h00, s[0], s[1], s[2], s[3], s[4], s[5], t});
	endtask
	task automatic silent();
		repeat (40) @(posedge sys_clk);
		chk(i_host.got_q.size(), 0);
	endtask
	task automatic remote();
		i_host.send("Z00XXX");
		i_host.send("I05XXX");
		silent();
	endtask
	task automatic cut(input string c, input int x);
		i_host.send($sformatf("%s%04d4", c, x));
		silent();
		i_host.send({c, "?XXXX"});
		reply($sformatf("%s%04d4", c, x), 8'h06);
	endtask
	task automatic cal(input logic ok);
		int n;
		i_host.send("CXXXXX");
		for (n = 0; n < 50 && cal_start !== 1'b1; n++) @(posedge sys_clk);
		chk(n < 50, 1'b1);
		cal_ok <= ok;
		cal_done <= 1'b1;
		reply(ok ? "CXXXXX" : "E7XXXX", 8'h07);
		cal_done <= 1'b0;
	endtask
	task automatic cmd(input string s, input string r, input logic [7:0] t);
		i_host.send(s);
		if (r == "") silent();
		else reply(r, t);
	endtask
	initial begin
		void'($urandom(45322));
		{sys_clk, arst_n, warn_over_pin, alert_over_pin, cal_done, cal_ok} = '0;
		{nv_load_valid, hclk_sel, hwrite, htrans, haddr, hwdata, nv_seen} = '0;
		link_present_pin = 1'b1;
		hsize = 3'h2;
		nv_load_data = '0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		nv_load_data <= '{1'b0, 32'd100, 32'd1000, 32'd1000, 32'd1000};
		nv_load_valid <= 1'b1;
		@(posedge sys_clk);
		nv_load_valid <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({lo_hz_out, hi_hz_out}, {32'd100, 32'd1000});
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0001);
		ahb(1'b1, 8'h08, 32'h5);
		ahb(1'b0, 8'h08, 32'h0);
		chk(rd[7:0], 8'h05);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		remote();
		cmd("F1XXXX", "", 8'h0);
		chk(filt_in_out, 1'b1);
		cmd("F?XXXX", "F1XXXX", 8'h06);
		chk(nv_seen, 1'b1);
		for (int k = 0; k < 5; k++) begin
			v = (k < 2) ? (k ? 500 : 5) : $urandom_range(5, 500);
			cut("L", v);
			chk(lo_hz_out, 64'(v));
			v = (k < 2) ? (k ? 5000 : 50) : $urandom_range(50, 5000);
			cut("U", v);
			chk(hi_hz_out, 64'(v));
		end
		foreach (bad[i]) cmd(bad[i], "E1XXXX", 8'h07);
		chk(hi_hz_out, 64'(v));
		cmd("W00093", "E1XXXX", 8'h07);
		cmd("W10013", "E1XXXX", 8'h07);
		cmd("A10003", "", 8'h0);
		cmd("W05003", "", 8'h0);
		cmd("W?XXXX", "W05003", 8'h06);
		warn_over_pin <= 1'b1;
		alert_over_pin <= 1'b1;
		reply("K0XXXX", 8'h07);
		{warn_over_pin, alert_over_pin} <= 2'b00;
		silent();
		cmd("K?XXXX", "K0XXXX", 8'h07);
		cmd("RXXXXX", "", 8'h0);
		warn_over_pin <= 1'b1;
		reply("K0XXXX", 8'h07);
		warn_over_pin <= 1'b0;
		cmd("JXXXXX", "", 8'h0);
		chk(filt_in_out, 1'b1);
		ahb(1'b1, 8'h00, 32'h0000_0011);
		silent();
		chk(filt_in_out, 1'b0);
		ahb(1'b1, 8'h00, 32'h0000_0001);
		silent();
		chk(filt_in_out, 1'b1);
		ahb(1'b0, 8'h00, 32'h0);
		ahb(1'b1, 8'h00, rd & 32'hFFFF_FFFE);
		cmd("F0XXXX", "E0XXXX", 8'h07);
		ahb(1'b1, 8'h00, rd);
		cal(1'b1);
		cal(1'b0);
		link_present_pin <= 1'b0;
		cmd("F?XXXX", "", 8'h0);
		link_present_pin <= 1'b1;
		remote();
		cmd("F?XXXX", "F1XXXX", 8'h06);
		end_sim();
	end
endmodule
`default_nettype wire

// ### test/rfac_host.sv
`timescale 1ns/1ns
`default_nettype none
module rfac_host (
	input wire logic sys_clk,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	logic [7:0] got_q[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// The host stalls at random so replies meet both prompt and slow acceptance.
	always @(posedge sys_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_data);
		tx_ready <= ($urandom_range(0, 3) != 0);
	end
	// Six characters and a semicolon; released data is inverted so a stale byte never looks held.
	task automatic send(input string s);
		logic [7:0] b;
		for (int i = 0; i < 7; i++) begin
			b = (i == 6) ? 8'h3B : s[i];
			@(posedge sys_clk);
			rx_data <= b;
			rx_valid <= 1'b1;
			@(posedge sys_clk);
			rx_valid <= 1'b0;
			rx_data <= ~b;
		end
	endtask
endmodule
`default_nettype wire
